/* File: hw/tws_pkg.sv */
// Constants and types of the two-wire target block, plus its pin synchroniser.
//
// Function
// [RULE_01] Status codes read with prescaler bits zero.
// [RULE_02] Upper seven address bits give own address.
// [RULE_03] Address bit zero enables general call answer.
// [RULE_04] Software sets enable bit before target use.
// [RULE_05] Software sets ack enable, clears start/stop.
// [RULE_06] Direction bit one selects transmit, else receive.
// [RULE_07] Address match sets flag and status code.
// [RULE_08] Lost arbitration then read reports 0xB0.
// [RULE_09] Ack enable cleared: last byte, then C0/C8.
// [RULE_10] After last byte leave, release data line.
// [RULE_11] Ack enable zero ignores own address.
// [RULE_12] Asleep, still match address from bus clock.
// [RULE_13] Wake on match, hold clock until cleared.
// [RULE_14] Data register need not hold last bus byte.
// [RULE_15] State 0x90: next byte, ack per enable.
// [RULE_16] After NACK on data, leave once cleared.
// [RULE_17] STOP or restart while addressed gives 0xA0.
// [RULE_18] Re-recognise own address only with ack enable.
// [RULE_19] Start request pending: START once bus free.
// [RULE_20] Own read address acknowledged reports 0xA8.
// [RULE_21] Data byte acked reports 0xB8, then next.
// [RULE_22] Flag set while addressed stretches bus clock.
`timescale 1ns/1ps

package tws_pkg;

  // ==========================================================
  // Register offsets and fields
  localparam logic [1:0] REG_OWN  = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam logic [1:0] REG_DATA = 2'h3;

  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK  = 6;
  localparam int CTL_STA  = 5;
  localparam int CTL_WCOL = 3;
  localparam int CTL_EN   = 2;

  localparam logic [7:0] CTRL_WMASK = 8'h75;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] OWN_RST    = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'hff;
  localparam logic [6:0] GC_ADDR    = 7'h00;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  // ==========================================================
  // Status codes
  localparam logic [7:0] STAT_RX_OWN    = 8'h60;
  localparam logic [7:0] STAT_RX_OWN_AL = 8'h68;
  localparam logic [7:0] STAT_RX_GC     = 8'h70;
  localparam logic [7:0] STAT_RX_GC_AL  = 8'h78;
  localparam logic [7:0] STAT_RX_ACK    = 8'h80;
  localparam logic [7:0] STAT_RX_NACK   = 8'h88;
  localparam logic [7:0] STAT_GC_ACK    = 8'h90;
  localparam logic [7:0] STAT_GC_NACK   = 8'h98;
  localparam logic [7:0] STAT_STOP      = 8'ha0;
  localparam logic [7:0] STAT_TX_OWN    = 8'ha8;
  localparam logic [7:0] STAT_TX_OWN_AL = 8'hb0;
  localparam logic [7:0] STAT_TX_ACK    = 8'hb8;
  localparam logic [7:0] STAT_TX_NACK   = 8'hc0;
  localparam logic [7:0] STAT_TX_LAST   = 8'hc8;
  localparam logic [7:0] STAT_NONE      = 8'hf8;

  // ==========================================================
  // Sequencer states
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_ADDR = 8'h02,
    S_ACKA = 8'h04,
    S_HOLD = 8'h08,
    S_RX   = 8'h10,
    S_RACK = 8'h20,
    S_TX   = 8'h40,
    S_TACK = 8'h80
  } tws_state_t;

endpackage

// ==========================================================
// Two-stage synchroniser, idle high like the bus lines.
module tws_sync2 #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      meta_reg <= '1;
      sync_o   <= '1;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

/* File: hw/tws_target.sv */
// Target-side sequencer and registers of the two-wire serial interface.
`timescale 1ns/1ps

module tws_target (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  input  wire logic       arb_lost_i,
  input  wire logic       sleep_i,
  output logic            wake_o,
  output logic            start_gen_o
);

  // ==========================================================
  // Pin sampling and bus conditions
  logic [1:0] pin_sync;
  logic       scl_s;
  logic       sda_s;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       busy_reg;

  tws_sync2 #(.WIDTH(2)) u_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .async_i   ({scl_i, sda_i}),
    .sync_o    (pin_sync)
  );

  assign scl_s = pin_sync[1];
  assign sda_s = pin_sync[0];

  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      busy_reg  <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      if (start_det) begin
        busy_reg <= 1'b1;
      end else if (stop_det) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  logic [7:0] own_address_cfg_reg;
  logic [7:0] interface_control_reg;
  logic [7:0] bus_data_reg;
  logic       write_collision_reg;

  wire ctrl_wr = reg_wr_i && (reg_addr_i == tws_pkg::REG_CTRL);
  wire data_wr = reg_wr_i && (reg_addr_i == tws_pkg::REG_DATA);

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      own_address_cfg_reg   <= tws_pkg::OWN_RST;
      interface_control_reg <= tws_pkg::CTRL_RST;
    end else begin
      if (reg_wr_i && (reg_addr_i == tws_pkg::REG_OWN)) begin
        own_address_cfg_reg <= reg_wdata_i;
      end
      if (ctrl_wr) begin
        interface_control_reg <= reg_wdata_i & tws_pkg::CTRL_WMASK;
      end
    end
  end

  // Software must set the enable bit; until then the sequencer stays reset.
  // [RULE_04] interface enable gate
  wire en_w     = interface_control_reg[tws_pkg::CTL_EN];
  wire ack_en_w = interface_control_reg[tws_pkg::CTL_ACK];

  // ==========================================================
  // Sequencer
  tws_pkg::tws_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] status_reg;
  logic       flag_reg;
  logic       ack_ph_reg;
  logic       gc_reg;
  logic       tx_reg;
  logic       ack_plan_reg;
  logic       last_reg;
  logic       got_ack_reg;
  logic       leave_reg;
  logic       arb_reg;
  logic       start_pend_reg;
  logic       start_gen_reg;
  logic       rx_load_reg;
  logic       wake_reg;
  logic       scl_oe_n_reg;
  logic       sda_oe_n_reg;

  wire [7:0] addr_byte = {shift_reg[6:0], sda_s};
  wire sw_clear = ctrl_wr && reg_wdata_i[tws_pkg::CTL_FLAG];
  wire in_xfer  = (state_reg == tws_pkg::S_ACKA) || (state_reg == tws_pkg::S_RX) ||
                  (state_reg == tws_pkg::S_RACK) || (state_reg == tws_pkg::S_TX) ||
                  (state_reg == tws_pkg::S_TACK);

  // [RULE_02] own address compare
  wire own_hit = ack_en_w && (addr_byte[7:1] == own_address_cfg_reg[7:1]);
  // [RULE_03] general call enable
  wire gc_hit  = ack_en_w && own_address_cfg_reg[0] &&
                 (addr_byte[7:1] == tws_pkg::GC_ADDR) && !addr_byte[0];

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !en_w) begin
      state_reg      <= tws_pkg::S_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      status_reg     <= tws_pkg::STAT_NONE;
      flag_reg       <= 1'b0;
      ack_ph_reg     <= 1'b0;
      gc_reg         <= 1'b0;
      tx_reg         <= 1'b0;
      ack_plan_reg   <= 1'b0;
      last_reg       <= 1'b0;
      got_ack_reg    <= 1'b0;
      leave_reg      <= 1'b0;
      arb_reg        <= 1'b0;
      start_pend_reg <= 1'b0;
      start_gen_reg  <= 1'b0;
      rx_load_reg    <= 1'b0;
      wake_reg       <= 1'b0;
      scl_oe_n_reg   <= 1'b1;
      sda_oe_n_reg   <= 1'b1;
    end else begin
      start_gen_reg <= 1'b0;
      rx_load_reg   <= 1'b0;
      if (arb_lost_i) begin
        arb_reg <= 1'b1;
      end
      if (!sleep_i) begin
        wake_reg <= 1'b0;
      end
      // A clear that meets a new event loses: the set below comes later.
      if (sw_clear) begin
        flag_reg <= 1'b0;
      end
      // [RULE_19] start once bus free
      if (start_pend_reg && !busy_reg && (state_reg == tws_pkg::S_IDLE)) begin
        start_gen_reg  <= 1'b1;
        start_pend_reg <= 1'b0;
      end
      // [RULE_17] stop or restart report
      if ((start_det || stop_det) && in_xfer) begin
        status_reg   <= tws_pkg::STAT_STOP;
        flag_reg     <= 1'b1;
        leave_reg    <= 1'b1;
        sda_oe_n_reg <= 1'b1;
        state_reg    <= tws_pkg::S_HOLD;
      end else if (start_det && (state_reg != tws_pkg::S_HOLD)) begin
        state_reg   <= tws_pkg::S_ADDR;
        bit_cnt_reg <= 4'h0;
      end else if (stop_det && (state_reg != tws_pkg::S_HOLD)) begin
        state_reg <= tws_pkg::S_IDLE;
      end else begin
        unique case (state_reg)
          tws_pkg::S_IDLE: begin
          end
          // The sampler keeps running while asleep, so matching goes on.
          // [RULE_12] match while asleep
          tws_pkg::S_ADDR: begin
            if (scl_rise) begin
              shift_reg   <= addr_byte;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == tws_pkg::LAST_BIT) begin
                // [RULE_11] ignore own address
                // [RULE_18] recognition needs ack enable
                if (own_hit || gc_hit) begin
                  // [RULE_06] direction selects mode
                  state_reg  <= tws_pkg::S_ACKA;
                  gc_reg     <= gc_hit;
                  tx_reg     <= addr_byte[0];
                  ack_ph_reg <= 1'b0;
                  // [RULE_13] wake on match
                  if (sleep_i) begin
                    wake_reg <= 1'b1;
                  end
                end else begin
                  state_reg <= tws_pkg::S_IDLE;
                end
              end
            end
          end
          tws_pkg::S_ACKA: begin
            if (scl_fall) begin
              if (!ack_ph_reg) begin
                sda_oe_n_reg <= 1'b0;
                ack_ph_reg   <= 1'b1;
              end else begin
                // [RULE_07] post address status
                sda_oe_n_reg <= 1'b1;
                flag_reg     <= 1'b1;
                scl_oe_n_reg <= 1'b0;
                leave_reg    <= 1'b0;
                arb_reg      <= 1'b0;
                state_reg    <= tws_pkg::S_HOLD;
                // [RULE_08] lost arbitration codes
                // [RULE_20] own read acknowledged
                if (tx_reg) begin
                  status_reg <= arb_reg ? tws_pkg::STAT_TX_OWN_AL : tws_pkg::STAT_TX_OWN;
                end else if (gc_reg) begin
                  status_reg <= arb_reg ? tws_pkg::STAT_RX_GC_AL : tws_pkg::STAT_RX_GC;
                end else begin
                  status_reg <= arb_reg ? tws_pkg::STAT_RX_OWN_AL : tws_pkg::STAT_RX_OWN;
                end
              end
            end
          end
          // [RULE_22] stretch until flag cleared
          tws_pkg::S_HOLD: begin
            if (!flag_reg) begin
              scl_oe_n_reg <= 1'b1;
              bit_cnt_reg  <= 4'h0;
              if (leave_reg) begin
                // [RULE_16] leave after nack
                state_reg      <= tws_pkg::S_IDLE;
                start_pend_reg <= interface_control_reg[tws_pkg::CTL_STA];
              end else if (tx_reg) begin
                // [RULE_21] send next, maybe last
                shift_reg    <= bus_data_reg;
                sda_oe_n_reg <= bus_data_reg[7];
                last_reg     <= !ack_en_w;
                state_reg    <= tws_pkg::S_TX;
              end else begin
                // [RULE_15] next byte ack plan
                ack_plan_reg <= ack_en_w;
                state_reg    <= tws_pkg::S_RX;
              end
            end
          end
          tws_pkg::S_RX: begin
            if (scl_rise) begin
              shift_reg   <= addr_byte;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == tws_pkg::LAST_BIT) begin
                state_reg  <= tws_pkg::S_RACK;
                ack_ph_reg <= 1'b0;
              end
            end
          end
          tws_pkg::S_RACK: begin
            if (scl_fall) begin
              if (!ack_ph_reg) begin
                sda_oe_n_reg <= !ack_plan_reg;
                ack_ph_reg   <= 1'b1;
              end else begin
                sda_oe_n_reg <= 1'b1;
                rx_load_reg  <= 1'b1;
                flag_reg     <= 1'b1;
                scl_oe_n_reg <= 1'b0;
                leave_reg    <= !ack_plan_reg;
                state_reg    <= tws_pkg::S_HOLD;
                if (gc_reg) begin
                  status_reg <= ack_plan_reg ? tws_pkg::STAT_GC_ACK : tws_pkg::STAT_GC_NACK;
                end else begin
                  status_reg <= ack_plan_reg ? tws_pkg::STAT_RX_ACK : tws_pkg::STAT_RX_NACK;
                end
              end
            end
          end
          tws_pkg::S_TX: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              shift_reg <= {shift_reg[6:0], 1'b1};
              if (bit_cnt_reg == tws_pkg::BYTE_BITS) begin
                sda_oe_n_reg <= 1'b1;
                state_reg    <= tws_pkg::S_TACK;
              end else begin
                sda_oe_n_reg <= shift_reg[6];
              end
            end
          end
          tws_pkg::S_TACK: begin
            if (scl_rise) begin
              got_ack_reg <= !sda_s;
            end else if (scl_fall) begin
              flag_reg     <= 1'b1;
              scl_oe_n_reg <= 1'b0;
              state_reg    <= tws_pkg::S_HOLD;
              // [RULE_09] final byte outcome
              // [RULE_10] leave after last byte
              if (!got_ack_reg) begin
                status_reg <= tws_pkg::STAT_TX_NACK;
                leave_reg  <= 1'b1;
              end else if (last_reg) begin
                status_reg <= tws_pkg::STAT_TX_LAST;
                leave_reg  <= 1'b1;
              end else begin
                status_reg <= tws_pkg::STAT_TX_ACK;
                leave_reg  <= 1'b0;
              end
            end
          end
          default: begin
            state_reg <= tws_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Data register; address bytes never land here, so after a wake it
  // holds the last data byte, not the bus's last byte.
  // [RULE_14] no address byte capture
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      bus_data_reg        <= tws_pkg::DATA_RST;
      write_collision_reg <= 1'b0;
    end else if (rx_load_reg) begin
      bus_data_reg <= shift_reg;
    end else if (data_wr) begin
      if (flag_reg) begin
        bus_data_reg        <= reg_wdata_i;
        write_collision_reg <= 1'b0;
      end else begin
        write_collision_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read port and pin outputs
  // [RULE_01] prescaler bits read zero
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      unique case (reg_addr_i)
        tws_pkg::REG_OWN:  reg_rdata_o <= own_address_cfg_reg;
        tws_pkg::REG_CTRL: reg_rdata_o <= {flag_reg, interface_control_reg[6:4],
                                           write_collision_reg, interface_control_reg[2:0]};
        tws_pkg::REG_STAT: reg_rdata_o <= flag_reg ? status_reg : tws_pkg::STAT_NONE;
        tws_pkg::REG_DATA: reg_rdata_o <= bus_data_reg;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign scl_oe_n_o  = scl_oe_n_reg;
  assign sda_oe_n_o  = sda_oe_n_reg;
  assign wake_o      = wake_reg;
  assign start_gen_o = start_gen_reg;

  // ==========================================================
  // Checks
  chk_status_low_zero: assert property ( // [RULE_01]
    @(posedge clock_i) disable iff (!reset_n_i)
    status_reg[2:0] == 3'h0)
    else $error("status code has nonzero prescaler bits");

  chk_noack_own_addr: assert property ( // [RULE_11]
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == tws_pkg::S_ADDR) && scl_rise && (bit_cnt_reg == 4'h7) && !ack_en_w
    |=> state_reg != tws_pkg::S_ACKA)
    else $error("address acknowledged with ack enable low");

  chk_gc_disabled: assert property ( // [RULE_03]
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == tws_pkg::S_ADDR) && scl_rise && (bit_cnt_reg == 4'h7) &&
    !own_address_cfg_reg[0] && (addr_byte[7:1] == 7'h00) &&
    (own_address_cfg_reg[7:1] != 7'h00)
    |=> state_reg != tws_pkg::S_ACKA)
    else $error("general call answered while disabled");

  chk_addr_post: assert property ( // [RULE_07]
    @(posedge clock_i) disable iff (!reset_n_i)
    en_w && (state_reg == tws_pkg::S_ACKA) && ack_ph_reg && scl_fall
    |=> flag_reg && (state_reg == tws_pkg::S_HOLD) && !scl_oe_n_o)
    else $error("address match did not post status");

  chk_hold_stretch: assert property ( // [RULE_22]
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == tws_pkg::S_HOLD) && flag_reg && (status_reg != tws_pkg::STAT_STOP)
    |-> !scl_oe_n_o)
    else $error("clock not stretched while flag set");

  chk_leave_idle: assert property ( // [RULE_10]
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == tws_pkg::S_HOLD) && !flag_reg && leave_reg
    |=> (state_reg == tws_pkg::S_IDLE) && sda_oe_n_o && scl_oe_n_o)
    else $error("did not leave addressed state");

  chk_last_ack_c8: assert property ( // [RULE_09]
    @(posedge clock_i) disable iff (!reset_n_i)
    en_w && (state_reg == tws_pkg::S_TACK) && scl_fall && last_reg && got_ack_reg
    |=> (status_reg == tws_pkg::STAT_TX_LAST) && flag_reg)
    else $error("ack after last byte not reported as c8");

  chk_start_free: assert property ( // [RULE_19]
    @(posedge clock_i) disable iff (!reset_n_i)
    start_gen_o |-> !$past(busy_reg))
    else $error("start issued on busy bus");

  chk_rx_ack_plan: assert property ( // [RULE_15]
    @(posedge clock_i) disable iff (!reset_n_i)
    en_w && (state_reg == tws_pkg::S_HOLD) && !flag_reg && !leave_reg && !tx_reg
    |=> (state_reg == tws_pkg::S_RX) && (ack_plan_reg == $past(ack_en_w)))
    else $error("receive ack plan not taken from ack enable");

endmodule

/* File: tb/tws_bus_master.sv */
// Behavioural two-wire bus master facing the target block.
`timescale 1ns/1ps

module tws_bus_master (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic scl_i,
  input  wire logic sda_i
);
  // Half of the 125 ns link clock; the clock stands high between frames.
  localparam realtime HALF = 62.5;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Releases the clock and waits while the target stretches it.
  task automatic rise();
    int n = 0;
    scl_o = 1'b1;
    while (scl_i !== 1'b1 && n < 5000) begin
      #10 n++;
    end
  endtask

  task automatic bit_x(input logic b, output logic r);
    sda_o = b;
    #HALF rise();
    #HALF r = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic start();
    sda_o = 1'b1;
    #HALF rise();
    #HALF sda_o = 1'b0;
    #HALF scl_o = 1'b0;
  endtask

  task automatic stop();
    sda_o = 1'b0;
    #HALF rise();
    #HALF sda_o = 1'b1;
    #HALF;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                      output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ai, ao);
  endtask
endmodule

/* File: tb/tws_target_tb_top.sv */
// Self-checking bench for the two-wire target block.
`timescale 1ns/1ps

module tws_target_tb_top;
  logic       clock_i   = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [1:0] reg_addr  = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       arb_lost  = 1'b0;
  logic       sleep     = 1'b0;
  logic [7:0] reg_rdata;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, wake, start_gen, m_scl, m_sda, ack;
  logic [7:0] rx;
  int         n_mismatch  = 0;
  int         check_count = 0;
  int         n_start     = 0;
  // Open-drain lines with pull-ups.
  wire        scl_w = m_scl & (scl_oe_n | scl_o);
  wire        sda_w = m_sda & (sda_oe_n | sda_o);

  tws_target i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .arb_lost_i(arb_lost), .sleep_i(sleep), .wake_o(wake),
    .start_gen_o(start_gen));
  tws_bus_master i_master (.scl_o(m_scl), .sda_o(m_sda), .scl_i(scl_w), .sda_i(sda_w));

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (start_gen === 1'b1) begin
      n_start++;
    end
  end

  // ==========================================================
  // Access and compare tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    #1 chk8(reg_rdata, exp);
  endtask

  task automatic chk_stat(input logic [7:0] code);
    chk_reg(tws_pkg::REG_STAT, code);
  endtask

  task automatic clr(input logic [7:0] c);
    wr(tws_pkg::REG_CTRL, c);
  endtask

  // Polls the control register until the step-done flag shows.
  task automatic wait_flag();
    int n = 0;
    while (i_dut.reg_rdata_o[7] !== 1'b1 && n < 200) begin
      @(posedge clock_i);
      reg_addr <= tws_pkg::REG_CTRL;
      reg_rd   <= 1'b1;
      @(posedge clock_i);
      reg_rd <= 1'b0;
      #1 n++;
    end
    chk1(reg_rdata[7], 1'b1);
  endtask

  task automatic addr(input logic [7:0] a, input logic an, input logic [7:0] code);
    i_master.start();
    i_master.xfer(a, 1'b1, rx, ack);
    chk1(ack, an);
    if (an === 1'b0) begin
      wait_flag();
      chk_stat(code);
    end
  endtask

  task automatic rx_byte(input logic [7:0] b, input logic an, input logic [7:0] code);
    i_master.xfer(b, 1'b1, rx, ack);
    chk1(ack, an);
    wait_flag();
    chk_stat(code);
  endtask

  task automatic tx_byte(input logic ai, input logic [7:0] exp, input logic [7:0] code);
    i_master.xfer(8'hff, ai, rx, ack);
    chk8(rx, exp);
    wait_flag();
    chk_stat(code);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1'b1;
    chk_reg(tws_pkg::REG_OWN, tws_pkg::OWN_RST);
    chk_reg(tws_pkg::REG_CTRL, tws_pkg::CTRL_RST);
    chk_stat(tws_pkg::STAT_NONE);
    chk_reg(tws_pkg::REG_DATA, tws_pkg::DATA_RST);
    $display("test reset done");
    wr(tws_pkg::REG_OWN, 8'h40);
    clr(8'h04);
    addr(8'h40, 1'b1, 8'h00);
    i_master.stop();
    clr(8'h44);
    addr(8'h00, 1'b1, 8'h00);
    i_master.stop();
    $display("test isolation done");
    addr(8'h40, 1'b0, tws_pkg::STAT_RX_OWN);
    chk1(scl_oe_n, 1'b0);
    clr(8'hc4);
    rx_byte(8'h5a, 1'b0, tws_pkg::STAT_RX_ACK);
    chk_reg(tws_pkg::REG_DATA, 8'h5a);
    clr(8'h84);
    rx_byte(8'ha5, 1'b1, tws_pkg::STAT_RX_NACK);
    clr(8'hc4);
    i_master.stop();
    wr(tws_pkg::REG_OWN, 8'h41);
    addr(8'h00, 1'b0, tws_pkg::STAT_RX_GC);
    clr(8'hc4);
    rx_byte(8'h11, 1'b0, tws_pkg::STAT_GC_ACK);
    clr(8'h84);
    rx_byte(8'h22, 1'b1, tws_pkg::STAT_GC_NACK);
    clr(8'hc4);
    i_master.stop();
    $display("test receive done");
    addr(8'h41, 1'b0, tws_pkg::STAT_TX_OWN);
    wr(tws_pkg::REG_DATA, 8'hc3);
    clr(8'hc4);
    tx_byte(1'b0, 8'hc3, tws_pkg::STAT_TX_ACK);
    wr(tws_pkg::REG_DATA, 8'h3c);
    clr(8'h84);
    tx_byte(1'b0, 8'h3c, tws_pkg::STAT_TX_LAST);
    clr(8'hc4);
    i_master.xfer(8'hff, 1'b1, rx, ack);
    chk8(rx, 8'hff);
    i_master.stop();
    @(posedge clock_i) arb_lost <= 1'b1;
    @(posedge clock_i) arb_lost <= 1'b0;
    addr(8'h41, 1'b0, tws_pkg::STAT_TX_OWN_AL);
    wr(tws_pkg::REG_DATA, 8'h81);
    clr(8'hc4);
    tx_byte(1'b1, 8'h81, tws_pkg::STAT_TX_NACK);
    clr(8'hc4);
    i_master.stop();
    $display("test transmit done");
    addr(8'h40, 1'b0, tws_pkg::STAT_RX_OWN);
    clr(8'hc4);
    i_master.stop();
    wait_flag();
    chk_stat(tws_pkg::STAT_STOP);
    clr(8'he4);
    for (int n = 0; n < 200 && n_start == 0; n++) begin
      @(posedge clock_i);
    end
    chk8(n_start[7:0], 8'h01);
    clr(8'h44);
    $display("test stop done");
    @(posedge clock_i) sleep <= 1'b1;
    addr(8'h40, 1'b0, tws_pkg::STAT_RX_OWN);
    chk1(wake, 1'b1);
    chk1(scl_oe_n, 1'b0);
    chk_reg(tws_pkg::REG_DATA, 8'h81);
    @(posedge clock_i) sleep <= 1'b0;
    clr(8'hc4);
    repeat (3) @(posedge clock_i);
    #1 chk1(scl_oe_n, 1'b1);
    chk1(wake, 1'b0);
    i_master.stop();
    wait_flag();
    clr(8'hc4);
    wr(tws_pkg::REG_DATA, 8'h55);
    chk_reg(tws_pkg::REG_CTRL, 8'h4c);
    chk_reg(tws_pkg::REG_DATA, 8'h81);
    $display("test sleep done");
    wrap_up();
  end
endmodule
